// file: verilog/tx_buffer_command_path.v
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tx_path_defines.vh"
// Behaviour
// - each buffer preceded by two command words
// - command words are 32-bit buffer parameters
// - packet bounds come from command bits only
// - tag of second word copied into status
// - tag opaque, only compared within packet
// - second word mismatch in packet sets error
// - delivered bytes differ from length: error
// - payload starts at offset within eight words
// - following buffers may start on any byte
// - end padding accepted and discarded
// - completion event after flagged buffer sent
// - one status entry per finished packet
// - status read pops one stored word
// - enabled event at programmable status level
// - writing beyond free space sets error
// - 16-bit halves joined into 32-bit words
// - reported free space counts only retained data
// - bits 25:24 pick 4/16/32 byte end alignment
// - bit 31 enables buffer loaded flag

module tx_buffer_command_path #(
  parameter DATA_AW = 9,
  parameter STAT_AW = 5
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output wire [31:0] tx_data,
  output wire [1:0]  tx_start_byte,
  output wire [2:0]  tx_nbytes,
  output wire        tx_last,
  output reg         tx_valid,
  input  wire        tx_ready,
  input  wire        tx_end,
  input  wire        tx_fail,
  output reg         transmitter_error_flag,
  output reg         buffer_loaded_flag,
  output reg         status_level_event
);

  localparam [1:0] S_CMDA = 2'b00;
  localparam [1:0] S_CMDB = 2'b01;
  localparam [1:0] S_DATA = 2'b10;
  localparam [DATA_AW:0] DEPTH = {1'b1, {DATA_AW{1'b0}}};
  localparam [STAT_AW:0] SDEPTH = {1'b1, {STAT_AW{1'b0}}};

  reg  [1:0]           state_q;
  reg  [31:0]          cmda_q;
  reg  [31:0]          cmdb_q;
  reg  [31:0]          pkt_b_q;
  reg                  pkt_open_q;
  reg  [13:0]          wcnt_q;
  reg  [15:0]          byte_acc_q;
  reg  [DATA_AW-1:0]   dwr_q;
  reg  [DATA_AW-1:0]   drd_q;
  reg  [DATA_AW:0]     dcnt_q;
  reg  [STAT_AW-1:0]   swr_q;
  reg  [STAT_AW-1:0]   srd_q;
  reg  [STAT_AW:0]     scnt_q;
  reg  [8:0]           ctrl_q;
  reg  [15:0]          sent_tag_q;
  reg                  pop_hit_q;
  reg  [31:0]          rd_mux;
  reg  [13:0]          mask;
  wire                 word_v;
  wire [31:0]          word;
  wire [`ENTRY_W-1:0]  dq;
  wire [31:0]          sq;

  // apb phases: setup, first access, final access
  wire setup = psel & ~penable;
  wire acc1  = psel & penable & ~pready;
  wire fin   = psel & penable & pready;
  wire wr_fin = fin & pwrite;
  wire mapped = (paddr == `OFF_DATA) | (paddr == `OFF_STATUS) | (paddr == `OFF_INFO) |
                (paddr == `OFF_FLAGS) | (paddr == `OFF_CTRL);

  // 16-bit halves joined into internal words
  half_joiner u_join (
    .clk        (pclk),
    .rst_n      (presetn),
    .half_valid (wr_fin & (paddr == `OFF_DATA)),
    .half_data  (pwdata[15:0]),
    .word_valid (word_v),
    .word_data  (word)
  );

  // command field decode
  wire        ioc   = cmda_q[`CA_IOC];
  wire [1:0]  align = cmda_q[`CA_ALIGN_HI:`CA_ALIGN_LO];
  wire [4:0]  off   = cmda_q[`CA_OFF_HI:`CA_OFF_LO];
  wire        fs    = cmda_q[`CA_FS];
  wire        ls    = cmda_q[`CA_LS];
  wire [10:0] size  = cmda_q[`CA_SIZE_HI:0];
  wire [10:0] len   = cmdb_q[`CB_LEN_HI:0];
  wire [15:0] tag   = cmdb_q[`CB_TAG_HI:`CB_TAG_LO];

  // end alignment mask in words
  always @* begin
    case (align)
      `ALIGN_16: mask = `MASK_16;
      `ALIGN_32: mask = `MASK_32;
      default:   mask = `MASK_4;
    endcase
  end

  // word span of payload and of padded buffer
  wire [15:0] off16   = {{11{1'b0}}, off};
  wire [15:0] span    = off16 + {{5{1'b0}}, size};
  wire [15:0] span_r  = span + 16'h0003;
  wire [13:0] dwords  = span_r[15:2];
  wire [13:0] total   = (dwords + mask) & ~mask;

  // byte window of the current word
  wire [15:0] lo4     = {wcnt_q, 2'b00};
  wire [15:0] hi4     = lo4 + 16'h0003;
  wire [15:0] last_b  = span - 16'h0001;
  wire [15:0] lo      = (lo4 > off16) ? lo4 : off16;
  wire [15:0] hi      = (hi4 < last_b) ? hi4 : last_b;
  wire [15:0] nb16    = hi - lo + 16'h0001;
  wire [2:0]  nb      = nb16[2:0];

  wire in_data   = (state_q == S_DATA) & word_v;
  wire last_word = (wcnt_q == dwords - 14'h0001);
  wire keep      = in_data & (wcnt_q < dwords) & (hi >= lo);
  wire bend      = in_data & (wcnt_q == total - 14'h0001);
  wire zero_buf  = (state_q == S_CMDB) & word_v & (total == 14'h0000);
  wire buf_end   = bend | zero_buf;
  wire dfull     = (dcnt_q == DEPTH);
  wire push      = keep & ~dfull;
  wire ovf       = keep & dfull;
  wire [15:0] acc_base = ((state_q == S_CMDB) & fs) ? 16'h0000 : byte_acc_q;
  wire [15:0] acc_sum = acc_base + (keep ? {{13{1'b0}}, nb} : 16'h0000);
  wire len_err   = buf_end & ls & (acc_sum != {{5{1'b0}}, len});
  wire b_err     = (state_q == S_CMDB) & word_v & ~fs & pkt_open_q & (word != pkt_b_q);
  wire [`ENTRY_W-1:0] entry = {ioc & last_word, ls & last_word, lo[1:0], nb, tag, word};

  // transmit side of data fifo
  wire rd_issue  = (dcnt_q != {(DATA_AW+1){1'b0}}) & (~tx_valid | tx_ready);
  wire handshake = tx_valid & tx_ready;

  word_ram #(
    .WIDTH (`ENTRY_W),
    .AW    (DATA_AW)
  ) u_data_ram (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (push),
    .wr_addr (dwr_q),
    .wr_data (entry),
    .rd_en   (rd_issue),
    .rd_addr (drd_q),
    .rd_data (dq)
  );

  assign tx_data       = dq[`E_DATA_HI:0];
  assign tx_start_byte = dq[`E_SB_HI:`E_SB_LO];
  assign tx_nbytes     = dq[`E_NB_HI:`E_NB_LO];
  assign tx_last       = dq[`E_LAST];

  // status fifo
  wire sfull  = (scnt_q == SDEPTH);
  wire s_push = tx_end & ~sfull;
  wire s_pop  = setup & ~pwrite & (paddr == `OFF_STATUS) & (scnt_q != {(STAT_AW+1){1'b0}});
  wire [31:0] s_word = {sent_tag_q, {`ST_PAD_W{1'b0}}, tx_fail};

  word_ram #(
    .WIDTH (32),
    .AW    (STAT_AW)
  ) u_stat_ram (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (s_push),
    .wr_addr (swr_q),
    .wr_data (s_word),
    .rd_en   (s_pop),
    .rd_addr (srd_q),
    .rd_data (sq)
  );

  // command sequencing and packet tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= S_CMDA;
      cmda_q     <= 32'h00000000;
      cmdb_q     <= 32'h00000000;
      pkt_b_q    <= 32'h00000000;
      pkt_open_q <= 1'b0;
      wcnt_q     <= 14'h0000;
      byte_acc_q <= 16'h0000;
    end else begin
      case (state_q)
        S_CMDA: begin
          if (word_v) begin
            cmda_q  <= word;
            state_q <= S_CMDB;
          end
        end
        S_CMDB: begin
          if (word_v) begin
            cmdb_q <= word;
            wcnt_q <= 14'h0000;
            if (fs) begin
              pkt_b_q    <= word;
              pkt_open_q <= 1'b1;
              byte_acc_q <= 16'h0000;
            end
            state_q <= zero_buf ? S_CMDA : S_DATA;
            if (zero_buf & ls) begin
              pkt_open_q <= 1'b0;
            end
          end
        end
        S_DATA: begin
          if (word_v) begin
            wcnt_q     <= wcnt_q + 14'h0001;
            byte_acc_q <= acc_sum;
            if (bend) begin
              state_q <= S_CMDA;
              if (ls) begin
                pkt_open_q <= 1'b0;
              end
            end
          end
        end
        default: state_q <= S_CMDA;
      endcase
    end
  end

  // fifo pointers and fill counts, only retained words counted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwr_q      <= {DATA_AW{1'b0}};
      drd_q      <= {DATA_AW{1'b0}};
      dcnt_q     <= {(DATA_AW+1){1'b0}};
      tx_valid   <= 1'b0;
      swr_q      <= {STAT_AW{1'b0}};
      srd_q      <= {STAT_AW{1'b0}};
      scnt_q     <= {(STAT_AW+1){1'b0}};
      sent_tag_q <= 16'h0000;
    end else begin
      if (push) begin
        dwr_q <= dwr_q + {{(DATA_AW-1){1'b0}}, 1'b1};
      end
      if (rd_issue) begin
        drd_q <= drd_q + {{(DATA_AW-1){1'b0}}, 1'b1};
      end
      dcnt_q <= dcnt_q + {{DATA_AW{1'b0}}, push} - {{DATA_AW{1'b0}}, rd_issue};
      tx_valid <= rd_issue | (tx_valid & ~tx_ready);
      if (handshake & dq[`E_LAST]) begin
        sent_tag_q <= dq[`E_TAG_HI:`E_TAG_LO];
      end
      if (s_push) begin
        swr_q <= swr_q + {{(STAT_AW-1){1'b0}}, 1'b1};
      end
      if (s_pop) begin
        srd_q <= srd_q + {{(STAT_AW-1){1'b0}}, 1'b1};
      end
      scnt_q <= scnt_q + {{STAT_AW{1'b0}}, s_push} - {{STAT_AW{1'b0}}, s_pop};
    end
  end

  // sticky flags, set wins over write-one-to-clear
  wire [31:0] clr = (wr_fin & (paddr == `OFF_FLAGS)) ? pwdata : 32'h00000000;
  wire [7:0]  scnt8 = {{(7-STAT_AW){1'b0}}, scnt_q};
  wire lvl_hit = ctrl_q[`CTL_EN] & (scnt8 >= ctrl_q[`CTL_LVL_HI:0]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmitter_error_flag <= 1'b0;
      buffer_loaded_flag     <= 1'b0;
      status_level_event     <= 1'b0;
      ctrl_q                 <= `CTRL_RST;
    end else begin
      transmitter_error_flag <= ovf | len_err | b_err |
                                (transmitter_error_flag & ~clr[`FLG_ERR]);
      buffer_loaded_flag <= (handshake & dq[`E_IOC]) |
                            (buffer_loaded_flag & ~clr[`FLG_DONE]);
      status_level_event <= lvl_hit | (status_level_event & ~clr[`FLG_LVL]);
      if (wr_fin & (paddr == `OFF_CTRL)) begin
        ctrl_q <= pwdata[`CTL_EN:0];
      end
    end
  end

  // read data selection
  always @* begin
    case (paddr)
      `OFF_STATUS: rd_mux = pop_hit_q ? sq : 32'h00000000;
      `OFF_INFO:   rd_mux = {8'h00, scnt8, {{(15-DATA_AW){1'b0}}, DEPTH - dcnt_q}};
      `OFF_FLAGS:  rd_mux = {{29{1'b0}}, status_level_event, buffer_loaded_flag,
                             transmitter_error_flag};
      `OFF_CTRL:   rd_mux = {{23{1'b0}}, ctrl_q};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // apb answer: ready in second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      pop_hit_q <= 1'b0;
    end else begin
      pready  <= acc1;
      pslverr <= acc1 & ~mapped;
      if (setup) begin
        pop_hit_q <= s_pop;
      end
      if (acc1) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

endmodule // tx_buffer_command_path

`default_nettype wire

// file: include/tx_path_defines.vh
`ifndef TX_PATH_DEFINES_VH
`define TX_PATH_DEFINES_VH

// register byte offsets
`define OFF_DATA      8'h00
`define OFF_STATUS    8'h04
`define OFF_INFO      8'h08
`define OFF_FLAGS     8'h0C
`define OFF_CTRL      8'h10

// first command word fields
`define CA_IOC        31
`define CA_ALIGN_HI   25
`define CA_ALIGN_LO   24
`define CA_OFF_HI     20
`define CA_OFF_LO     16
`define CA_FS         13
`define CA_LS         12
`define CA_SIZE_HI    10

// second command word fields
`define CB_TAG_HI     31
`define CB_TAG_LO     16
`define CB_LEN_HI     10

// end alignment codes
`define ALIGN_16      2'b01
`define ALIGN_32      2'b10
`define MASK_4        14'h0000
`define MASK_16       14'h0003
`define MASK_32       14'h0007

// flag register bits
`define FLG_ERR       0
`define FLG_DONE      1
`define FLG_LVL       2

// control register fields
`define CTL_LVL_HI    7
`define CTL_EN        8
`define CTRL_RST      9'h001

// data fifo entry layout
`define ENTRY_W       55
`define E_DATA_HI     31
`define E_TAG_HI      47
`define E_TAG_LO      32
`define E_NB_HI       50
`define E_NB_LO       48
`define E_SB_HI       52
`define E_SB_LO       51
`define E_LAST        53
`define E_IOC         54

// status word filler between tag and fail bit
`define ST_PAD_W      15

`endif

// file: verilog/word_ram.v
`timescale 1ns/1ps
`default_nettype none

module word_ram #(
  parameter WIDTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             rd_en,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // storage write
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // word_ram

`default_nettype wire

// file: verilog/half_joiner.v
`timescale 1ns/1ps
`default_nettype none

module half_joiner (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        half_valid,
  input  wire [15:0] half_data,
  output reg         word_valid,
  output reg  [31:0] word_data
);

  reg        upper_q;
  reg [15:0] low_q;

  // low half first, upper half completes the word
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_q    <= 1'b0;
      low_q      <= 16'h0000;
      word_valid <= 1'b0;
      word_data  <= 32'h00000000;
    end else begin
      word_valid <= half_valid & upper_q;
      if (half_valid) begin
        upper_q <= ~upper_q;
        if (upper_q) begin
          word_data <= {half_data, low_q};
        end else begin
          low_q <= half_data;
        end
      end
    end
  end

endmodule // half_joiner

`default_nettype wire

// file: sim/tx_path_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_path_defines.vh"

module tx_path_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] tx_data,
  input wire logic [1:0]  tx_start_byte,
  input wire logic [2:0]  tx_nbytes,
  input wire logic        tx_last,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        transmitter_error_flag,
  input wire logic        buffer_loaded_flag,
  input wire logic        status_level_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // flag clear strobes and the mapped window
  wire logic [2:0] clr = {3{psel && penable && pready && pwrite && paddr == `OFF_FLAGS}}
                         & pwdata[2:0];
  wire logic       map = paddr[1:0] == 2'h0 && paddr <= `OFF_CTRL;

  chk_answer_late: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_bad_addr: assert property (pready |-> pslverr == !map)
    else $error("error response does not match address");
  chk_read_zero: assert property (pready && !pwrite && (!map || paddr == `OFF_DATA)
    |-> prdata == 32'h0) else $error("nonzero read data");
  chk_err_sticky: assert property (transmitter_error_flag && !clr[0]
    |=> transmitter_error_flag) else $error("error flag dropped");
  chk_done_sticky: assert property (buffer_loaded_flag && !clr[1]
    |=> buffer_loaded_flag) else $error("loaded flag dropped");
  chk_level_sticky: assert property (status_level_event && !clr[2]
    |=> status_level_event) else $error("level event dropped");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
    && $stable(tx_last) && $stable(tx_nbytes)) else $error("word changed while stalled");
  chk_lane_fit: assert property (tx_valid |-> tx_nbytes != 3'h0
    && {1'b0, tx_start_byte} + tx_nbytes <= 3'h4) else $error("byte lanes out of word");

  cover property ($rose(transmitter_error_flag));
  cover property (tx_valid && tx_ready && tx_last);
  cover property ($rose(status_level_event));
endmodule // tx_path_properties

bind tx_buffer_command_path tx_path_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_data(tx_data), .tx_start_byte(tx_start_byte), .tx_nbytes(tx_nbytes),
  .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .transmitter_error_flag(transmitter_error_flag),
  .buffer_loaded_flag(buffer_loaded_flag), .status_level_event(status_level_event));
`default_nettype wire

// file: sim/tx_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module tx_engine_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] tx_data,
  input  wire logic [1:0]  tx_start_byte,
  input  wire logic [2:0]  tx_nbytes,
  input  wire logic        tx_last,
  input  wire logic        tx_valid,
  input  wire logic        hold,
  input  wire logic        fail,
  output logic             tx_ready,
  output logic             tx_end,
  output logic             tx_fail
);
  logic [7:0] got[$];
  logic [2:0] cnt_q;
  logic       slow_q;
  int         n_end;

  // takes a word every other cycle, ends a packet three cycles after its last word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_q <= 1'b0;
      cnt_q  <= 3'h0;
      tx_end <= 1'b0;
    end else begin
      slow_q <= ~slow_q;
      tx_end <= cnt_q == 3'h1;
      if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
      if (tx_end) n_end <= n_end + 1;
      if (tx_valid && tx_ready) begin
        for (int i = 0; i < tx_nbytes; i++) got.push_back(tx_data[8*(tx_start_byte+i)+:8]);
        if (tx_last) cnt_q <= 3'h3;
      end
    end
  end
  // stall on request; outcome only meaningful with the end pulse
  assign tx_ready = !hold && slow_q;
  assign tx_fail  = tx_end ? fail : !fail;
endmodule // tx_engine_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_path_defines.vh"
`define CHK(a,b) begin n_checks++; if ((a)!==(b)) begin mismatches++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end

module tb;
  logic [31:0] pwdata, prdata, tx_data, rd;
  logic [7:0]  paddr;
  logic [7:0]  ex[$];
  logic [2:0]  tx_nbytes;
  logic [1:0]  tx_start_byte;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, hold, fail;
  logic        tx_last, tx_valid, tx_ready, tx_end, tx_fail, err_f, done_f, lvl_f;
  int          mismatches, n_checks, cyc, ne;

  tx_buffer_command_path #(.DATA_AW(3), .STAT_AW(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_start_byte(tx_start_byte), .tx_nbytes(tx_nbytes),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_end(tx_end),
    .tx_fail(tx_fail), .transmitter_error_flag(err_f), .buffer_loaded_flag(done_f),
    .status_level_event(lvl_f));
  tx_engine_model eng (
    .pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_start_byte(tx_start_byte),
    .tx_nbytes(tx_nbytes), .tx_last(tx_last), .tx_valid(tx_valid), .hold(hold),
    .fail(fail), .tx_ready(tx_ready), .tx_end(tx_end), .tx_fail(tx_fail));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // hang guard, far above the several hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus transfer, held until ready
  task xf(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task r(input logic [7:0] a); xf(1'b0, a, 32'h0); endtask
  task w(input logic [7:0] a, input logic [31:0] d); xf(1'b1, a, d); endtask
  task wd(input logic [31:0] d);
    w(`OFF_DATA, {16'h0, d[15:0]});
    w(`OFF_DATA, {16'h0, d[31:16]});
  endtask
  // both command words, then payload bytes counting up from s
  task bf(input logic [31:0] a, b, input int nw, input logic [7:0] s);
    wd(a); wd(b);
    for (int k = 0; k < nw; k++)
      wd({s + 8'(4*k+3), s + 8'(4*k+2), s + 8'(4*k+1), s + 8'(4*k)});
    for (int i = 0; i < a[10:0]; i++) ex.push_back(s + 8'(a[20:16] + i));
  endtask
  task we;
    ne++;
    while (eng.n_end < ne) @(posedge pclk);
    @(posedge pclk);
  endtask
  task cmp;
    `CHK(eng.got.size(), ex.size())
    foreach (ex[i]) `CHK(eng.got[i], ex[i])
    ex.delete();
    eng.got.delete();
  endtask

  task t_reset;
    r(`OFF_INFO); `CHK(rd[23:0], 24'h000008)
    r(`OFF_CTRL); `CHK(rd, {23'h0, `CTRL_RST})
    r(`OFF_FLAGS); `CHK(rd, 32'h0)
    `CHK({err_f, done_f, lvl_f}, 3'h0)
    r(`OFF_STATUS); `CHK(rd, 32'h0)
    r(8'h14); `CHK({er, rd}, 33'h100000000)
  endtask
  // offset 5, six bytes, 16-byte end padding, engine stalled
  task t_offset;
    hold <= 1'b1;
    bf(32'h01053006, 32'hA5C30006, 4, 8'h10);
    repeat (8) @(posedge pclk);
    r(`OFF_INFO); `CHK(rd[15:0] == 16'h6 || rd[15:0] == 16'h7, 1'b1)
    hold <= 1'b0;
    we(); cmp();
    r(`OFF_STATUS); `CHK(rd, 32'hA5C30000)
    r(`OFF_FLAGS); `CHK(rd, 32'h0)
  endtask
  // two buffers, second starts on byte 1 with 32-byte padding, fails
  task t_multi;
    fail <= 1'b1;
    bf(32'h00022003, 32'hFFFF0007, 2, 8'h40);
    bf(32'h82011004, 32'hFFFF0007, 8, 8'h80);
    we(); cmp();
    r(`OFF_STATUS); `CHK(rd, 32'hFFFF0001)
    r(`OFF_FLAGS); `CHK(rd, 32'h2)
    `CHK(done_f, 1'b1)
    w(`OFF_FLAGS, 32'h2);
    r(`OFF_FLAGS); `CHK(rd, 32'h0)
    fail <= 1'b0;
  endtask
  // length one above size with reserved alignment, then differing tags
  task t_errors;
    bf(32'h03003004, 32'h00010005, 1, 8'h00);
    we(); cmp();
    repeat (20) @(posedge pclk);
    r(`OFF_FLAGS); `CHK(rd, 32'h1)
    w(`OFF_FLAGS, 32'h1);
    r(`OFF_FLAGS); `CHK(rd, 32'h0)
    bf(32'h00002004, 32'h00010008, 1, 8'h20);
    bf(32'h00001004, 32'h00020008, 1, 8'h30);
    we(); cmp();
    r(`OFF_FLAGS); `CHK(rd, 32'h1)
    `CHK(err_f, 1'b1)
    w(`OFF_FLAGS, 32'h1);
    r(`OFF_STATUS); `CHK(rd[31:16], 16'h0001)
    r(`OFF_STATUS); `CHK(rd[31:16], 16'h0002)
  endtask
  // event at two stored status words, second packet led by an empty buffer
  task t_level;
    w(`OFF_CTRL, 32'h102);
    r(`OFF_CTRL); `CHK(rd, 32'h102)
    bf(32'h00003004, 32'h00110004, 1, 8'h00);
    we();
    r(`OFF_FLAGS); `CHK(rd, 32'h0)
    bf(32'h00002000, 32'h00220004, 0, 8'h00);
    bf(32'h00001004, 32'h00220004, 1, 8'h00);
    we();
    r(`OFF_INFO); `CHK(rd[23:16], 8'h02)
    r(`OFF_FLAGS); `CHK(rd, 32'h4)
    `CHK(lvl_f, 1'b1)
    r(`OFF_STATUS); `CHK(rd, 32'h00110000)
    r(`OFF_STATUS); `CHK(rd, 32'h00220000)
    w(`OFF_FLAGS, 32'h4);
    r(`OFF_INFO); `CHK(rd[23:16], 8'h00)
    r(`OFF_FLAGS); `CHK(rd, 32'h0)
    cmp();
  endtask
  // twelve words into eight places while stalled
  task t_overflow;
    hold <= 1'b1;
    bf(32'h00003030, 32'h00330030, 12, 8'h00);
    hold <= 1'b0;
    repeat (30) @(posedge pclk);
    r(`OFF_FLAGS); `CHK(rd[0], 1'b1)
    r(`OFF_INFO); `CHK(rd[15:0], 16'h0008)
  endtask

  // reset, then the scenarios in turn
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hold, fail} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_offset();
    t_multi();
    t_errors();
    t_level();
    t_overflow();
    close_out();
  end
endmodule // tb
`default_nettype wire
